// [verilog/noe_exec.sv]
// Execution unit for negate, bitwise OR and no-operation instructions.
// Assumes instruction, extension words and memory read data come from
// logic on mclk; memory answers a read in the cycle after mem_rd_q.
`timescale 1ns/1ps

module noe_exec
   import noe_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Software register port
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rdata_q,
   // Instruction issue
   input wire logic start,
   input wire logic seg_mode,
   input wire logic [15:0] instr,
   input wire logic [15:0] ext1,
   input wire logic [15:0] ext2,
   output logic busy_q,
   output logic done_q,
   output logic illegal_q,
   output logic [7:0] flags_q,
   // Memory operand port
   input wire logic [15:0] mem_rdata,
   output logic mem_rd_q,
   output logic mem_wr_q,
   output logic mem_byte_q,
   output logic [22:0] mem_addr_q,
   output logic [15:0] mem_wdata_q
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Byte registers 0-7 are high halves, 8-15 low halves of words 0-7
   function automatic logic [15:0] get_op(input logic w,
      input logic [3:0] n, input logic [15:0] rw, input logic [15:0] rb);
      if (w) begin
         get_op = rw;
      end else if (n[3]) begin
         get_op = {8'h00, rb[7:0]};
      end else begin
         get_op = {8'h00, rb[15:8]};
      end
   endfunction : get_op

   function automatic logic [4:0] cyc_sel(input logic seg,
      input logic lng, input logic [4:0] ns, input logic [4:0] ss,
      input logic [4:0] sl);
      cyc_sel = seg ? (lng ? sl : ss) : ns;
   endfunction : cyc_sel

   logic [15:0] regs [16];
   noe_state_t st_q;
   noe_kind_t kind_q, kind_d;
   noe_mode_t mode_q, mode_d;
   logic [4:0] cnt_q, cyc_d;
   logic w_q, mem_q, mem_d;
   logic [3:0] fa_q, fb_q;
   logic [15:0] imm_q;
   logic [22:0] disp_d, ea_d;
   logic [15:0] reg_a, reg_b, src_v, res, mask;
   logic zero, msb, take, exec_we;
   logic [3:0] exec_idx;
   logic [3:0] fa, pair_hi, pair_lo;
   logic lng;

   assign take = start && st_q == ST_IDLE;

   // ----------------------------------------------------------------
   // Decode and effective address, evaluated in the issue cycle
   // ----------------------------------------------------------------
   assign fa = instr[7:4];
   assign pair_hi = {fa[3:1], 1'b0};
   assign pair_lo = {fa[3:1], 1'b1};
   assign lng = seg_mode && ext1[15];

   // Short segmented form carries an 8-bit offset in the first word
   always_comb begin
      if (!seg_mode) begin
         disp_d = {7'h00, ext1};
      end else if (lng) begin
         disp_d = {ext1[14:8], ext2};
      end else begin
         disp_d = {ext1[14:8], 8'h00, ext1[7:0]};
      end
   end

   // Form recognition; the tail nibble separates negate from no-op
   always_comb begin
      kind_d = K_BAD;
      mode_d = MD_R;
      cyc_d = CYC_BAD;
      ea_d = disp_d;
      if (instr == OP_NOP) begin
         kind_d = K_NOP;
         cyc_d = CYC_NOP; // [RULE_09]
      end else if (instr[3:0] == NEG_TAIL && instr[15:9] == OP_NEG_REG) begin
         kind_d = K_NEG;
         cyc_d = CYC_NEG_R; // [RULE_17]
      end else if (instr[3:0] == NEG_TAIL && instr[15:9] == OP_NEG_IND
                   && fa != 4'h0) begin
         kind_d = K_NEG;
         mode_d = MD_IR;
         cyc_d = CYC_NEG_IR; // [RULE_06]
      end else if (instr[3:0] == NEG_TAIL
                   && instr[15:9] == OP_NEG_MEM) begin
         kind_d = K_NEG;
         mode_d = (fa == 4'h0) ? MD_DA : MD_X;
         cyc_d = (fa == 4'h0) ? // [RULE_07] [RULE_08]
            cyc_sel(seg_mode, lng, CYC_NEG_DA_NS, CYC_NEG_DA_SS,
                    CYC_NEG_DA_SL) :
            cyc_sel(seg_mode, lng, CYC_NEG_X_NS, CYC_NEG_X_SS,
                    CYC_NEG_X_SL);
      end else if (instr[15:9] == OP_OR_REG) begin
         kind_d = K_OR;
         cyc_d = CYC_OR_R;
      end else if (instr[15:9] == OP_OR_IND) begin
         kind_d = K_OR;
         mode_d = (fa == 4'h0) ? MD_IM : MD_IR;
         cyc_d = (fa == 4'h0) ? CYC_OR_IM : CYC_OR_IR;
      end else if (instr[15:9] == OP_OR_MEM) begin
         kind_d = K_OR;
         mode_d = (fa == 4'h0) ? MD_DA : MD_X;
         cyc_d = (fa == 4'h0) ?
            cyc_sel(seg_mode, lng, CYC_OR_DA_NS, CYC_OR_DA_SS,
                    CYC_OR_DA_SL) :
            cyc_sel(seg_mode, lng, CYC_OR_X_NS, CYC_OR_X_SS,
                    CYC_OR_X_SL);
      end
      // Pointer is one word, or a segment/offset pair when segmented
      if (mode_d == MD_IR) begin
         ea_d = seg_mode ? {regs[pair_hi][14:8], regs[pair_lo]} // [RULE_15]
                         : {7'h00, regs[fa]};
      end else if (mode_d == MD_X) begin
         ea_d = {disp_d[22:16], disp_d[15:0] + regs[fa]};
      end
   end

   assign mem_d = mode_d == MD_IR || mode_d == MD_DA || mode_d == MD_X;

   // ----------------------------------------------------------------
   // Datapath, evaluated in the calculate state
   // ----------------------------------------------------------------
   assign reg_a = get_op(w_q, fa_q, regs[fa_q], regs[{1'b0, fa_q[2:0]}]);
   assign reg_b = get_op(w_q, fb_q, regs[fb_q], regs[{1'b0, fb_q[2:0]}]);
   assign mask = w_q ? 16'hffff : 16'h00ff; // [RULE_16]

   always_comb begin
      if (mem_q) begin
         src_v = mem_rdata & mask;
      end else if (mode_q == MD_IM) begin
         src_v = imm_q & mask;
      end else begin
         src_v = reg_a;
      end
      // Minimum value wraps onto itself, which is the intended answer
      if (kind_q == K_NEG) begin
         res = (16'h0000 - src_v) & mask; // [RULE_01] [RULE_02]
      end else begin
         res = reg_b | src_v; // [RULE_11]
      end
   end

   assign zero = res == 16'h0000;
   assign msb = w_q ? res[15] : res[7];
   assign exec_we = st_q == ST_CALC
      && ((kind_q == K_NEG && !mem_q) || kind_q == K_OR); // [RULE_10]
   assign exec_idx = (kind_q == K_OR) ? fb_q : fa_q;

   // ----------------------------------------------------------------
   // Sequencer: the count sets the whole instruction length
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_q <= ST_IDLE;
         cnt_q <= 5'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (st_q != ST_IDLE) begin
            cnt_q <= cnt_q - 5'h01;
         end
         case (st_q)
            ST_IDLE: begin
               if (take) begin
                  st_q <= ST_READ;
                  cnt_q <= cyc_d - 5'h01;
                  busy_q <= 1'b1;
               end
            end
            ST_READ: st_q <= ST_CALC;
            ST_CALC: st_q <= ST_WAIT;
            ST_WAIT: begin
               if (cnt_q == 5'h01) begin
                  st_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Instruction latch, taken once so later issue inputs may change
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         kind_q <= K_BAD;
         mode_q <= MD_R;
         w_q <= 1'b0;
         mem_q <= 1'b0;
         fa_q <= 4'h0;
         fb_q <= 4'h0;
         imm_q <= 16'h0000;
         illegal_q <= 1'b0;
      end else if (take) begin
         kind_q <= kind_d;
         mode_q <= mode_d;
         w_q <= instr[8]; // [RULE_16]
         mem_q <= mem_d;
         fa_q <= instr[7:4];
         fb_q <= instr[3:0];
         imm_q <= ext1;
         illegal_q <= kind_d == K_BAD;
      end
   end

   // ----------------------------------------------------------------
   // Memory operand port
   // ----------------------------------------------------------------
   // The read is issued at issue so the data is back for calculate
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_byte_q <= 1'b0;
         mem_addr_q <= 23'h000000;
         mem_wdata_q <= 16'h0000;
      end else begin
         mem_rd_q <= take && mem_d;
         mem_wr_q <= st_q == ST_CALC && kind_q == K_NEG && mem_q; // [RULE_01]
         if (take) begin
            mem_addr_q <= ea_d;
            mem_byte_q <= !instr[8];
         end
         if (st_q == ST_CALC) begin
            mem_wdata_q <= res;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   // Execution wins over a software write in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flags_q <= FLAGS_RST;
      end else if (st_q == ST_CALC && kind_q == K_NEG) begin
         flags_q[FLG_C] <= !zero; // [RULE_03]
         flags_q[FLG_Z] <= zero; // [RULE_04]
         flags_q[FLG_S] <= msb; // [RULE_04]
         flags_q[FLG_V] <= src_v == (w_q ? WORD_MIN : BYTE_MIN); // [RULE_05]
      end else if (st_q == ST_CALC && kind_q == K_OR) begin
         flags_q[FLG_Z] <= zero; // [RULE_12]
         flags_q[FLG_S] <= msb; // [RULE_13]
         if (!w_q) begin
            flags_q[FLG_V] <= ~^res[7:0]; // [RULE_14]
         end
      end else if (wr_en && addr == ADDR_FLAGS) begin
         flags_q <= wdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Register file and software port
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 16; i++) begin
            regs[i] <= REG_RST;
         end
      end else begin
         if (wr_en && !addr[4]) begin
            regs[addr[3:0]] <= wdata;
         end
         // Byte results touch only their half of the word register
         if (exec_we && w_q) begin
            regs[exec_idx] <= res;
         end else if (exec_we && exec_idx[3]) begin
            regs[{1'b0, exec_idx[2:0]}][7:0] <= res[7:0];
         end else if (exec_we) begin
            regs[{1'b0, exec_idx[2:0]}][15:8] <= res[7:0];
         end
      end
   end

   // Read data stands for one cycle; unmapped addresses read zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 16'h0000;
      end else if (!rd_en) begin
         rdata_q <= 16'h0000;
      end else if (!addr[4]) begin
         rdata_q <= regs[addr[3:0]];
      end else if (addr == ADDR_FLAGS) begin
         rdata_q <= {8'h00, flags_q};
      end else if (addr == ADDR_STATUS) begin
         rdata_q <= {14'h0000, illegal_q, busy_q};
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_neg_value: assert property (@(posedge mclk) disable iff (!resetn)
      st_q == ST_CALC && kind_q == K_NEG |=> // [RULE_01]
      ((mem_wdata_q + $past(src_v)) & $past(mask)) == 16'h0000)
      else $error("negate result is not the two's complement");
   a_neg_min_fix: assert property (@(posedge mclk) disable iff (!resetn)
      st_q == ST_CALC && kind_q == K_NEG && src_v == WORD_MIN && w_q
      |=> mem_wdata_q == WORD_MIN && flags_q[FLG_V]) // [RULE_02]
      else $error("most negative word not kept or overflow clear");
   a_neg_carry: assert property (@(posedge mclk) disable iff (!resetn)
      st_q == ST_CALC && kind_q == K_NEG |=> // [RULE_03]
      flags_q[FLG_C] == (mem_wdata_q != 16'h0000))
      else $error("negate carry does not match result");
   a_neg_sign: assert property (@(posedge mclk) disable iff (!resetn)
      st_q == ST_CALC && kind_q == K_NEG && w_q |=> // [RULE_04]
      flags_q[FLG_S] == mem_wdata_q[15] && !flags_q[FLG_Z] == |mem_wdata_q)
      else $error("negate sign or zero flag wrong");
   a_neg_ir_time: assert property (@(posedge mclk) disable iff (!resetn)
      take && instr[15:9] == OP_NEG_IND && instr[3:0] == NEG_TAIL
      && instr[7:4] != 4'h0 |-> ##12 done_q) // [RULE_06]
      else $error("indirect negate not 12 cycles");
   a_neg_da_long: assert property (@(posedge mclk) disable iff (!resetn)
      take && instr[15:9] == OP_NEG_MEM && instr[3:0] == NEG_TAIL
      && instr[7:4] == 4'h0 && lng |-> ##18 done_q) // [RULE_07]
      else $error("long direct negate not 18 cycles");
   a_neg_x_long: assert property (@(posedge mclk) disable iff (!resetn)
      take && instr[15:9] == OP_NEG_MEM && instr[3:0] == NEG_TAIL
      && instr[7:4] != 4'h0 && lng |-> ##19 done_q) // [RULE_08]
      else $error("long indexed negate not 19 cycles");
   a_nop_quiet: assert property (@(posedge mclk) disable iff (!resetn)
      take && instr == OP_NOP |=> $stable(flags_q) && !mem_wr_q
      ##6 done_q) // [RULE_09]
      else $error("no-operation changed state or not 7 cycles");
   a_neg_reg_time: assert property (@(posedge mclk) disable iff (!resetn)
      take && instr[15:9] == OP_NEG_REG && instr[3:0] == NEG_TAIL
      |-> ##7 done_q) // [RULE_17]
      else $error("register negate not 7 cycles");
   a_or_word_pv: assert property (@(posedge mclk) disable iff (!resetn)
      st_q == ST_CALC && kind_q == K_OR && w_q |=> // [RULE_14]
      $stable(flags_q[FLG_V]) && flags_q[FLG_Z] == (mem_wdata_q == 16'h0000))
      else $error("word OR touched overflow or zero flag wrong");

endmodule : noe_exec

// [verilog/noe_pkg.sv]
// Constants, encodings and types of the negate / OR / no-operation unit.
// Assumes a 16-bit datapath, 16 word registers and 7-bit segment numbers.
//
// Notes on behaviour
// RULE_01: Negate replaces the destination by its two's complement, in place.
// RULE_02: Most negative value negates to itself and sets overflow.
// RULE_03: Negate clears carry on a zero result, sets it otherwise (borrow).
// RULE_04: Negate sets zero on zero result, sign on negative result.
// RULE_05: Negate sets overflow only for the most negative operand.
// RULE_06: Indirect negate: opcode 0000110W, pointer nonzero, tail 0010; 12 cycles.
// RULE_07: Direct negate takes 15, 16 short segmented, 18 long segmented cycles.
// RULE_08: Indexed negate takes 16 cycles, 19 with a long segmented address.
// RULE_09: No-operation 8d07 changes nothing and takes 7 cycles in both modes.
// RULE_10: OR writes source OR destination to destination; source untouched.
// RULE_11: Each OR result bit is one when either operand bit is one.
// RULE_12: OR sets zero flag on a zero result, clears it otherwise.
// RULE_13: OR copies the result's top bit into the sign flag.
// RULE_14: Word OR keeps parity/overflow; byte OR sets it from result parity.
// RULE_15: Indirect pointer is a word register, or a register pair segmented.
// RULE_16: Width bit high selects word form, low selects byte registers.
// RULE_17: Register negate is 1000110W with tail 0010, 7 cycles both modes.

package noe_pkg;

   // ----------------------------------------------------------------
   // Opcode encodings (upper seven bits, width bit below them)
   // ----------------------------------------------------------------
   localparam logic [6:0] OP_NEG_REG = 7'h46;
   localparam logic [6:0] OP_NEG_IND = 7'h06;
   localparam logic [6:0] OP_NEG_MEM = 7'h26;
   localparam logic [6:0] OP_OR_REG = 7'h42;
   localparam logic [6:0] OP_OR_IND = 7'h02;
   localparam logic [6:0] OP_OR_MEM = 7'h22;
   localparam logic [3:0] NEG_TAIL = 4'h2;
   localparam logic [15:0] OP_NOP = 16'h8d07;

   // ----------------------------------------------------------------
   // Cycle counts per form: nonsegmented, short and long segmented
   // ----------------------------------------------------------------
   localparam logic [4:0] CYC_NEG_R = 5'h07;
   localparam logic [4:0] CYC_NEG_IR = 5'h0c;
   localparam logic [4:0] CYC_NEG_DA_NS = 5'h0f;
   localparam logic [4:0] CYC_NEG_DA_SS = 5'h10;
   localparam logic [4:0] CYC_NEG_DA_SL = 5'h12;
   localparam logic [4:0] CYC_NEG_X_NS = 5'h10;
   localparam logic [4:0] CYC_NEG_X_SS = 5'h10;
   localparam logic [4:0] CYC_NEG_X_SL = 5'h13;
   localparam logic [4:0] CYC_NOP = 5'h07;
   localparam logic [4:0] CYC_OR_R = 5'h04;
   localparam logic [4:0] CYC_OR_IM = 5'h07;
   localparam logic [4:0] CYC_OR_IR = 5'h07;
   localparam logic [4:0] CYC_OR_DA_NS = 5'h09;
   localparam logic [4:0] CYC_OR_DA_SS = 5'h0a;
   localparam logic [4:0] CYC_OR_DA_SL = 5'h0c;
   localparam logic [4:0] CYC_OR_X_NS = 5'h0a;
   localparam logic [4:0] CYC_OR_X_SS = 5'h0a;
   localparam logic [4:0] CYC_OR_X_SL = 5'h0d;
   localparam logic [4:0] CYC_BAD = 5'h04;

   // ----------------------------------------------------------------
   // Flags, software port map, reset values
   // ----------------------------------------------------------------
   localparam int FLG_C = 7;
   localparam int FLG_Z = 6;
   localparam int FLG_S = 5;
   localparam int FLG_V = 4;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [4:0] ADDR_FLAGS = 5'h10;
   localparam logic [4:0] ADDR_STATUS = 5'h11;
   localparam logic [15:0] WORD_MIN = 16'h8000;
   localparam logic [15:0] BYTE_MIN = 16'h0080;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_CALC = 2'b11,
      ST_WAIT = 2'b10
   } noe_state_t;

   typedef enum logic [1:0] {K_BAD, K_NEG, K_OR, K_NOP} noe_kind_t;
   typedef enum logic [2:0] {MD_R, MD_IM, MD_IR, MD_DA, MD_X} noe_mode_t;

endpackage : noe_pkg

// [tb/noe_exec_tb.sv]
// Self-checking bench for the negate / OR / no-operation unit.
// Assumes the bench plays software port, issuer and zero-wait memory.
`timescale 1ns/1ps

module noe_exec_tb
   import noe_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals, clock, memory model
   // ----------------------------------------------------------------
   logic mclk;
   logic resetn;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic wr_en;
   logic rd_en;
   logic [15:0] rdata_q;
   logic start;
   logic seg_mode;
   logic [15:0] instr;
   logic [15:0] ext1;
   logic [15:0] ext2;
   logic busy_q;
   logic done_q;
   logic illegal_q;
   logic [7:0] flags_q;
   logic [15:0] mem_rdata;
   logic mem_rd_q;
   logic mem_wr_q;
   logic mem_byte_q;
   logic [22:0] mem_addr_q;
   logic [15:0] mem_wdata_q;
   logic [15:0] mem [logic [22:0]];
   logic [3:0] f_keep;
   int err_total;
   int checks;
   int wr_cnt;
   int w_keep;

   noe_exec noe_exec_inst (.mclk(mclk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
      .start(start), .seg_mode(seg_mode), .instr(instr), .ext1(ext1),
      .ext2(ext2), .busy_q(busy_q), .done_q(done_q),
      .illegal_q(illegal_q), .flags_q(flags_q), .mem_rdata(mem_rdata),
      .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_byte_q(mem_byte_q),
      .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q));

   // Free-running 100 MHz clock
   always #5 mclk = ~mclk;

   // Zero-wait memory; idle data toggles so a late sample is caught
   always @(posedge mclk) begin
      if (mem_rd_q) begin
         mem_rdata <= mem.exists(mem_addr_q) ? mem[mem_addr_q] : 16'h0000;
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem_wr_q) begin
         mem[mem_addr_q] = mem_wdata_q;
         wr_cnt++;
      end
   end

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      if (err_total == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask : reg_wr

   // Read data stand only in the cycle after the strobe edge
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      check(rdata_q, exp);
   endtask : rd_chk

   task automatic fchk(input logic [3:0] f);
      check(16'(flags_q[7:4]), 16'(f));
   endtask : fchk

   // Issue one instruction and count edges from take to done
   task automatic run(input logic [15:0] op, input logic [15:0] e1,
      input logic [15:0] e2, input logic sg, input int n);
      int k;
      @(posedge mclk);
      start <= 1'b1;
      instr <= op;
      ext1 <= e1;
      ext2 <= e2;
      seg_mode <= sg;
      @(posedge mclk);
      start <= 1'b0;
      #1;
      // Done raised at edge N-1 is first sampled at edge N
      k = 1;
      while (done_q !== 1'b1 && k < 40) begin
         @(posedge mclk);
         #1;
         k++;
      end
      check(16'(k), 16'(n));
   endtask : run

   task automatic neg_r(input logic w, input logic [3:0] n,
      input logic [3:0] r, input logic [15:0] init, input logic [15:0] exp,
      input logic [3:0] f);
      reg_wr({1'b0, r}, init);
      run({OP_NEG_REG, w, n, NEG_TAIL}, 16'h0000, 16'h0000, w, 7);
      rd_chk({1'b0, r}, exp);
      fchk(f);
   endtask : neg_r

   task automatic neg_m(input logic [15:0] op, input logic [15:0] e1,
      input logic [15:0] e2, input logic sg, input logic [22:0] a,
      input logic [15:0] v, input int n);
      mem[a] = v;
      run(op, e1, e2, sg, n);
      check(mem[a], 16'h0000 - v);
   endtask : neg_m

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      {addr, wdata, wr_en, rd_en, start, seg_mode} = '0;
      {instr, ext1, ext2, mem_rdata} = '0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      // Register negate, word and both byte halves
      neg_r(1'b1, 4'h8, 4'h8, 16'h051f, 16'hfae1, 4'ha);
      neg_r(1'b1, 4'h8, 4'h8, 16'h8000, 16'h8000, 4'hb);
      neg_r(1'b1, 4'h8, 4'h8, 16'h0000, 16'h0000, 4'h4);
      neg_r(1'b1, 4'h1, 4'h1, 16'h0080, 16'hff80, 4'ha);
      neg_r(1'b0, 4'h1, 4'h1, 16'h8005, 16'h8005, 4'hb);
      neg_r(1'b0, 4'h9, 4'h1, 16'h1205, 16'h12fb, 4'ha);
      neg_r(1'b0, 4'h9, 4'h1, 16'h7f00, 16'h7f00, 4'h4);
      // Memory negate in every form and mode
      reg_wr(5'h02, 16'h0100);
      neg_m(16'h0d22, 16'h0000, 16'h0000, 1'b0, 23'h000100, 16'h0001, 12);
      reg_wr(5'h02, 16'h0500);
      reg_wr(5'h03, 16'h0200);
      neg_m(16'h0d22, 16'h0000, 16'h0000, 1'b1, 23'h050200, 16'h1234, 12);
      neg_m(16'h4d02, 16'h0300, 16'h0000, 1'b0, 23'h000300, 16'h0002, 15);
      neg_m(16'h4d02, 16'h0640, 16'h0000, 1'b1, 23'h060040, 16'h00ff, 16);
      neg_m(16'h4d02, 16'h8700, 16'h1234, 1'b1, 23'h071234, 16'hff00, 18);
      reg_wr(5'h04, 16'h0010);
      neg_m(16'h4d42, 16'h0400, 16'h0000, 1'b0, 23'h000410, 16'h0003, 16);
      neg_m(16'h4d42, 16'h0650, 16'h0000, 1'b1, 23'h060060, 16'h0004, 16);
      neg_m(16'h4d42, 16'h8700, 16'h2000, 1'b1, 23'h072010, 16'h0005, 19);
      // Byte negate in memory works on bits 7:0
      mem[23'h000320] = 16'h0005;
      run(16'h4c02, 16'h0320, 16'h0000, 1'b0, 15);
      check(16'(mem[23'h000320][7:0]), 16'h00fb);
      check(16'(mem_byte_q), 16'h0001);
      // No-operation in both modes leaves everything alone
      f_keep = flags_q[7:4];
      w_keep = wr_cnt;
      run(OP_NOP, 16'h0000, 16'h0000, 1'b0, 7);
      run(OP_NOP, 16'h0000, 16'h0000, 1'b1, 7);
      fchk(f_keep);
      check(16'(wr_cnt - w_keep), 16'h0000);
      rd_chk(5'h01, 16'h7f00);
      rd_chk(ADDR_STATUS, 16'h0000);
      // OR: set V first so the word forms must keep it
      reg_wr(5'h10, 16'h0010);
      reg_wr(5'h04, 16'h1200);
      reg_wr(5'h05, 16'h0034);
      run(16'h8554, 16'h0000, 16'h0000, 1'b0, 4);
      rd_chk(5'h04, 16'h1234);
      rd_chk(5'h05, 16'h0034);
      fchk(4'h1);
      reg_wr(5'h06, 16'h8000);
      reg_wr(5'h07, 16'h0001);
      run(16'h8576, 16'h0000, 16'h0000, 1'b1, 4);
      rd_chk(5'h06, 16'h8001);
      fchk(4'h3);
      reg_wr(5'h0a, 16'h0000);
      reg_wr(5'h0b, 16'h0000);
      run(16'h85ba, 16'h0000, 16'h0000, 1'b0, 4);
      fchk(4'h5);
      // Byte OR immediate: odd parity clears P/V
      reg_wr(5'h03, 16'h00c3);
      run(16'h040b, 16'h007b, 16'h0000, 1'b0, 7);
      rd_chk(5'h03, 16'h00fb);
      fchk(4'h2);
      // Byte OR high half with low half: even parity sets P/V
      run(16'h84c4, 16'h0000, 16'h0000, 1'b0, 4);
      rd_chk(5'h04, 16'h3634);
      fchk(4'h1);
      // Word OR from memory leaves the source untouched
      reg_wr(5'h02, 16'h0100);
      mem[23'h000100] = 16'h00f0;
      w_keep = wr_cnt;
      run(16'h0526, 16'h0000, 16'h0000, 1'b0, 7);
      rd_chk(5'h06, 16'h80f1);
      check(mem[23'h000100], 16'h00f0);
      check(16'(wr_cnt - w_keep), 16'h0000);
      check(16'(mem_byte_q), 16'h0000);
      close_out();
   end

   // Watchdog: the sequence needs a few hundred cycles; the limit is 10000
   initial begin
      #100000;
      err_total++;
      close_out();
   end

endmodule : noe_exec_tb
